/* File: rtl/pops_pkg.sv */
package pops_pkg;

    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int NUM_CNT  = 8;
    localparam int NUM_OUT  = 7;
    localparam int FB_IDX   = 7;
    localparam int TAP_W    = 3;
    localparam int CNT_W    = 9;
    localparam int NUM_SYNC = 4;

    // synchroniser lanes
    localparam int SY_PRI   = 0;
    localparam int SY_BAK   = 1;
    localparam int SY_REQ   = 2;
    localparam int SY_SHIFT = 3;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STEP     = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CNT_BASE = 8'h20;

    // field positions
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int STEP_IDX_LSB  = 0;
    localparam int STEP_DIR_BIT  = 3;
    localparam int STEP_PEND_BIT = 4;

    // reset values
    localparam logic [CNT_W-1:0] CNT_HIGH_RST = 9'h001;
    localparam logic [CNT_W-1:0] CNT_LOW_RST  = 9'h001;
    localparam logic [CNT_W-1:0] CNT_INIT_RST = 9'h001;
    localparam logic [TAP_W-1:0] CNT_TAP_RST  = 3'h0;
    localparam logic             RUN_RST      = 1'b0;

    // timing
    localparam int CLK_MHZ      = 100;
    localparam int LOSS_TIME_NS = 200;
    localparam int LOSS_CYC     = (LOSS_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int LOSS_W       = 8;
    localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(LOSS_CYC);
    localparam logic [1:0]        HOLD_LAST  = 2'h2;

    typedef enum logic [1:0] {
        POPS_MODE_MANUAL   = 2'h0,
        POPS_MODE_AUTO     = 2'h1,
        POPS_MODE_OVERRIDE = 2'h2
    } pops_mode_t;

    typedef enum logic [1:0] {
        POPS_SW_IDLE     = 2'h0,
        POPS_SW_GATE_OLD = 2'h1,
        POPS_SW_OPEN_NEW = 2'h3
    } pops_sw_state_t;

    typedef struct packed {
        logic [1:0]       pad;
        logic [CNT_W-1:0] init;
        logic [TAP_W-1:0] tap;
        logic [CNT_W-1:0] low;
        logic [CNT_W-1:0] high;
    } pops_cnt_cfg_t;

    typedef struct packed {
        logic busy;
        logic active;
        logic lost_bak;
        logic lost_pri;
    } pops_stat_t;

    localparam pops_cnt_cfg_t CNT_CFG_RST = '{
        pad:  2'h0,
        init: CNT_INIT_RST,
        tap:  CNT_TAP_RST,
        low:  CNT_LOW_RST,
        high: CNT_HIGH_RST
    };

endpackage : pops_pkg

/* File: rtl/pops_top.sv */
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module pops_top
    import pops_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WR_DATA,
    input  wire logic              WR_STB,
    input  wire logic              RD_STB,
    output logic      [DATA_W-1:0] RD_DATA,
    input  wire logic              REF_CLOCK_PRIMARY,
    input  wire logic              REF_CLOCK_BACKUP,
    input  wire logic              SWITCH_REQUEST,
    input  wire logic              RECONFIG_SHIFT_CLOCK,
    output logic                   REF_MUX_OUT,
    output logic                   LOST_PRIMARY,
    output logic                   LOST_BACKUP,
    output logic                   ACTIVE_SOURCE,
    output logic      [NUM_OUT-1:0] DIV_OUT,
    output logic                   FEEDBACK_OUT
);

    function automatic logic cnt_hit(
        input logic [ADDR_W-1:0] addr,
        input int                idx
    );
        cnt_hit = (addr == OFS_CNT_BASE + ADDR_W'(idx * 4));
    endfunction : cnt_hit

    // pin synchronisers; stage three only feeds edge detection
    logic [NUM_SYNC-1:0] sync1_r;
    logic [NUM_SYNC-1:0] sync2_r;
    logic [NUM_SYNC-1:0] sync3_r;

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end
        else
        begin
            sync1_r <= {RECONFIG_SHIFT_CLOCK, SWITCH_REQUEST,
                        REF_CLOCK_BACKUP, REF_CLOCK_PRIMARY};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    wire [NUM_SYNC-1:0] rise = sync2_r & ~sync3_r;
    wire [NUM_SYNC-1:0] fall = ~sync2_r & sync3_r;

    // control registers
    logic                run_r;
    pops_mode_t          mode_r;
    pops_cnt_cfg_t       cfg_r [NUM_CNT];
    logic                step_pend_r;
    logic [TAP_W-1:0]    step_idx_r;
    logic                step_dir_r;
    logic [DATA_W-1:0]   rd_data_r;

    wire wr_ctrl = WR_STB && (ADDR == OFS_CTRL);
    wire wr_step = WR_STB && (ADDR == OFS_STEP);
    wire step_go = step_pend_r && rise[SY_SHIFT];

    // a new step request wins over completion of the previous one
    wire step_pend_nxt = wr_step ? 1'b1 : (step_go ? 1'b0 : step_pend_r);

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            run_r       <= RUN_RST;
            mode_r      <= POPS_MODE_MANUAL;
            step_pend_r <= 1'b0;
            step_idx_r  <= '0;
            step_dir_r  <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                run_r  <= WR_DATA[CTRL_RUN_BIT];
                mode_r <= pops_mode_t'(WR_DATA[CTRL_MODE_LSB +: 2]);
            end
            if (wr_step)
            begin
                step_idx_r <= WR_DATA[STEP_IDX_LSB +: TAP_W];
                step_dir_r <= WR_DATA[STEP_DIR_BIT];
            end
            step_pend_r <= step_pend_nxt;
        end
    end

    // oscillator model: one period spans eight system cycles, one per tap
    logic [TAP_W-1:0] phase_r;

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            phase_r <= '0;
        else
            phase_r <= phase_r + 3'h1;
    end

    // post-scale counters 0..6 and feedback counter 7
    logic [NUM_CNT-1:0] cnt_out_r;
    logic [NUM_CNT-1:0] cnt_hi_r;
    logic [CNT_W-1:0]   cnt_val_r [NUM_CNT];
    logic [CNT_W-1:0]   cnt_dly_r [NUM_CNT];

    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++)
        begin : g_cnt
            wire            wr_cfg  = WR_STB && cnt_hit(ADDR, g);
            wire            step_me = step_go && (step_idx_r == TAP_W'(g));
            wire [TAP_W-1:0] tap_up = cfg_r[g].tap + 3'h1;
            wire [TAP_W-1:0] tap_dn = cfg_r[g].tap - 3'h1;
            pops_cnt_cfg_t  cfg_stepped;
            pops_cnt_cfg_t  cfg_nxt;
            always_comb
            begin
                cfg_stepped     = cfg_r[g];
                cfg_stepped.tap = step_dir_r ? tap_dn : tap_up;
            end
            assign cfg_nxt = wr_cfg  ? pops_cnt_cfg_t'(WR_DATA) :
                             step_me ? cfg_stepped : cfg_r[g];

            // each counter ticks on its own oscillator tap
            wire tick   = (phase_r == cfg_r[g].tap);
            wire in_dly = (cnt_dly_r[g] != '0);
            wire last   = (cnt_val_r[g] == 9'h001);

            wire [CNT_W-1:0] dly_nxt =
                !run_r        ? cfg_r[g].init - 9'h001 :
                (tick && in_dly) ? cnt_dly_r[g] - 9'h001 : cnt_dly_r[g];

            wire run_tick = run_r && tick && !in_dly;

            // high count then low count; divide value is their sum
            wire [CNT_W-1:0] val_nxt =
                !run_r    ? cfg_r[g].high :
                !run_tick ? cnt_val_r[g] :
                last      ? (cnt_hi_r[g] ? cfg_r[g].low : cfg_r[g].high) :
                            cnt_val_r[g] - 9'h001;

            wire hi_nxt  = !run_r ? 1'b1 :
                           (run_tick && last) ? ~cnt_hi_r[g] : cnt_hi_r[g];
            wire out_nxt = !run_r ? 1'b0 :
                           run_tick ? cnt_hi_r[g] : cnt_out_r[g];

            always_ff @(posedge CLK_SYS or posedge RST)
            begin
                if (RST)
                begin
                    cfg_r[g]     <= CNT_CFG_RST;
                    cnt_dly_r[g] <= '0;
                    cnt_val_r[g] <= CNT_HIGH_RST;
                    cnt_hi_r[g]  <= 1'b1;
                    cnt_out_r[g] <= 1'b0;
                end
                else
                begin
                    cfg_r[g]     <= cfg_nxt;
                    cnt_dly_r[g] <= dly_nxt;
                    cnt_val_r[g] <= val_nxt;
                    cnt_hi_r[g]  <= hi_nxt;
                    cnt_out_r[g] <= out_nxt;
                end
            end
        end
    endgenerate

    // clock sense: a reference is lost after LOSS_CYC cycles with no rise
    logic [LOSS_W-1:0] loss_cnt_r [2];
    logic [1:0]        lost_r;

    generate
        for (g = 0; g < 2; g++)
        begin : g_sense
            wire stale = (loss_cnt_r[g] == LOSS_LIMIT);
            wire [LOSS_W-1:0] loss_nxt =
                rise[g] ? '0 : (stale ? loss_cnt_r[g] : loss_cnt_r[g] + 8'h01);
            always_ff @(posedge CLK_SYS or posedge RST)
            begin
                if (RST)
                begin
                    loss_cnt_r[g] <= '0;
                    lost_r[g]     <= 1'b0;
                end
                else
                begin
                    loss_cnt_r[g] <= loss_nxt;
                    lost_r[g]     <= (loss_nxt == LOSS_LIMIT);
                end
            end
        end
    endgenerate

    // switchover control; the backup source is whatever sits on lane one
    pops_sw_state_t sw_state_r;
    pops_sw_state_t sw_state_nxt;
    logic           sel_r;
    logic           sel_nxt;
    logic           gate_r;
    logic           gate_nxt;
    logic           arm_r;
    logic [1:0]     hold_r;
    logic           mux_r;

    wire req      = sync2_r[SY_REQ];
    wire req_rise = rise[SY_REQ];
    wire cur_lost = sel_r ? lost_r[SY_BAK] : lost_r[SY_PRI];
    wire new_ok   = sel_r ? !lost_r[SY_PRI] : !lost_r[SY_BAK];
    wire cur_rise = sel_r ? rise[SY_BAK] : rise[SY_PRI];
    wire old_fall = sel_r ? fall[SY_BAK] : fall[SY_PRI];
    wire new_fall = sel_r ? fall[SY_PRI] : fall[SY_BAK];

    wire mode_man  = (mode_r == POPS_MODE_MANUAL);
    wire mode_auto = (mode_r == POPS_MODE_AUTO);
    wire mode_ovr  = (mode_r == POPS_MODE_OVERRIDE);

    wire auto_trig = (mode_auto || (mode_ovr && !req))
                     && cur_lost && new_ok;
    wire man_trig  = mode_man && arm_r && req && cur_rise
                     && (hold_r == HOLD_LAST);
    wire ovr_trig  = mode_ovr && req_rise;
    wire trig      = auto_trig || man_trig || ovr_trig;

    // manual request qualification counts rises of the selected reference
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            arm_r  <= 1'b0;
            hold_r <= '0;
        end
        else if (!mode_man || !req)
        begin
            arm_r  <= 1'b0;
            hold_r <= '0;
        end
        else if (req_rise)
        begin
            arm_r  <= 1'b1;
            hold_r <= '0;
        end
        else if (arm_r && cur_rise)
        begin
            arm_r  <= (hold_r != HOLD_LAST);
            hold_r <= hold_r + 2'h1;
        end
    end

    always_comb
    begin
        sw_state_nxt = sw_state_r;
        sel_nxt      = sel_r;
        gate_nxt     = gate_r;
        case (sw_state_r)
            POPS_SW_IDLE:
            begin
                if (trig)
                    sw_state_nxt = POPS_SW_GATE_OLD;
            end
            POPS_SW_GATE_OLD:
            begin
                // a stopped clock never falls again, so gate at once
                if (old_fall || cur_lost)
                begin
                    gate_nxt     = 1'b0;
                    sw_state_nxt = POPS_SW_OPEN_NEW;
                end
            end
            POPS_SW_OPEN_NEW:
            begin
                if (new_ok && new_fall)
                begin
                    sel_nxt      = ~sel_r;
                    gate_nxt     = 1'b1;
                    sw_state_nxt = POPS_SW_IDLE;
                end
            end
            default:
            begin
                sw_state_nxt = POPS_SW_IDLE;
                gate_nxt     = 1'b1;
            end
        endcase
    end

    // the reference is passed through as sampled, forced low while gate_nxt is clear
    wire mux_nxt = gate_nxt && (sel_nxt ? sync2_r[SY_BAK] : sync2_r[SY_PRI]);

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            sw_state_r <= POPS_SW_IDLE;
            sel_r      <= 1'b0;
            gate_r     <= 1'b1;
            mux_r      <= 1'b0;
        end
        else
        begin
            sw_state_r <= sw_state_nxt;
            sel_r      <= sel_nxt;
            gate_r     <= gate_nxt;
            mux_r      <= mux_nxt;
        end
    end

    // register read port, data one cycle after the strobe
    pops_stat_t stat;
    assign stat = '{
        busy:     (sw_state_r != POPS_SW_IDLE),
        active:   sel_r,
        lost_bak: lost_r[SY_BAK],
        lost_pri: lost_r[SY_PRI]
    };

    logic [DATA_W-1:0] cnt_rd;
    always_comb
    begin
        cnt_rd = '0;
        for (int i = 0; i < NUM_CNT; i++)
        begin
            if (cnt_hit(ADDR, i))
                cnt_rd = cfg_r[i];
        end
    end

    wire [DATA_W-1:0] rd_sel =
        (ADDR == OFS_CTRL)   ? {29'h0, 2'(mode_r), run_r} :
        (ADDR == OFS_STATUS) ? {28'h0, stat} :
        (ADDR == OFS_STEP)   ? {27'h0, step_pend_r, step_dir_r, step_idx_r} :
                               cnt_rd;

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            rd_data_r <= '0;
        else
            rd_data_r <= RD_STB ? rd_sel : '0;
    end

    assign RD_DATA       = rd_data_r;
    assign REF_MUX_OUT   = mux_r;
    assign LOST_PRIMARY  = lost_r[SY_PRI];
    assign LOST_BACKUP   = lost_r[SY_BAK];
    assign ACTIVE_SOURCE = sel_r;
    assign DIV_OUT       = cnt_out_r[NUM_OUT-1:0];
    assign FEEDBACK_OUT  = cnt_out_r[FB_IDX];

endmodule : pops_top

/* File: tb/pops_chk.sv */
`timescale 1ns/1ps

module pops_chk
    import pops_pkg::*;
(
    input wire logic               CLK_SYS,
    input wire logic               RST,
    input wire logic [ADDR_W-1:0]  ADDR,
    input wire logic [DATA_W-1:0]  WR_DATA,
    input wire logic               WR_STB,
    input wire logic               RD_STB,
    input wire logic [DATA_W-1:0]  RD_DATA,
    input wire logic               REF_CLOCK_PRIMARY,
    input wire logic               REF_CLOCK_BACKUP,
    input wire logic               SWITCH_REQUEST,
    input wire logic               REF_MUX_OUT,
    input wire logic               LOST_PRIMARY,
    input wire logic               LOST_BACKUP,
    input wire logic               ACTIVE_SOURCE,
    input wire logic [NUM_OUT-1:0] DIV_OUT,
    input wire logic               FEEDBACK_OUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic             run_r, pri_d, bak_d;
    logic [1:0]       mode_r;
    logic [CNT_W-1:0] hi1_r;
    logic [11:0]      hi_cnt;
    logic [7:0]       pri_q, bak_q, req_hi;
    wire  [2:0]       st = {ACTIVE_SOURCE, LOST_BACKUP, LOST_PRIMARY};
    // shadow of what software wrote, so rules can depend on mode and counts
    always_ff @(posedge CLK_SYS or posedge RST)
        if (RST)
        begin
            {run_r, mode_r, hi1_r, hi_cnt, req_hi} <= '0;
            {pri_d, bak_d, pri_q, bak_q} <= '0;
        end
        else
        begin
            if (WR_STB && ADDR == OFS_CTRL)
                {mode_r, run_r} <= WR_DATA[2:0];
            if (WR_STB && ADDR == OFS_CNT_BASE + 8'h04)
                hi1_r <= WR_DATA[8:0];
            hi_cnt <= DIV_OUT[1] ? hi_cnt + 12'h1 : 12'h0;
            req_hi <= !SWITCH_REQUEST ? 8'h0 : req_hi + {7'h0, req_hi != 8'hff};
            pri_d  <= REF_CLOCK_PRIMARY;
            bak_d  <= REF_CLOCK_BACKUP;
            pri_q  <= REF_CLOCK_PRIMARY != pri_d ? 8'h0 : pri_q + {7'h0, pri_q != 8'hff};
            bak_q  <= REF_CLOCK_BACKUP != bak_d ? 8'h0 : bak_q + {7'h0, bak_q != 8'hff};
        end
    a_status_read: assert property ($past(RD_STB) && $past(ADDR) == OFS_STATUS
        && $past(st) == st && $past(st, 2) == st |-> RD_DATA[2:0] == st)
        else $error("status read differs from status pins");
    a_mux_gate: assert property ($changed(ACTIVE_SOURCE) |-> !$past(REF_MUX_OUT))
        else $error("selection changed while mux output open");
    a_lost_pri: assert property ($rose(LOST_PRIMARY) |-> pri_q >= 8'd12)
        else $error("primary flagged lost while toggling");
    a_lost_bak: assert property ($rose(LOST_BACKUP) |-> bak_q >= 8'd12)
        else $error("backup flagged lost while toggling");
    a_run_off: assert property (!run_r && !$past(run_r) && !$past(run_r, 2)
        |-> DIV_OUT == '0 && !FEEDBACK_OUT)
        else $error("counter output active while stopped");
    a_high_time: assert property (run_r && $fell(DIV_OUT[1])
        |-> hi_cnt == {hi1_r, 3'h0})
        else $error("high time differs from high count");
    a_override_hold: assert property (mode_r == POPS_MODE_OVERRIDE && req_hi == 8'hff
        |-> $stable(ACTIVE_SOURCE))
        else $error("switch while override request held");
    a_auto_switch: assert property (mode_r == POPS_MODE_AUTO && (ACTIVE_SOURCE ?
        LOST_BACKUP && !LOST_PRIMARY : LOST_PRIMARY && !LOST_BACKUP)
        |-> ##[1:30] $changed(ACTIVE_SOURCE))
        else $error("no switch away from lost reference");
    c_lost: cover property ($rose(LOST_PRIMARY));
    c_override: cover property ($changed(ACTIVE_SOURCE) && mode_r == POPS_MODE_OVERRIDE);
    c_high: cover property (run_r && $fell(DIV_OUT[1]));
endmodule : pops_chk

bind pops_top pops_chk u_chk (.CLK_SYS, .RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA,
    .REF_CLOCK_PRIMARY, .REF_CLOCK_BACKUP, .SWITCH_REQUEST, .REF_MUX_OUT, .LOST_PRIMARY,
    .LOST_BACKUP, .ACTIVE_SOURCE, .DIV_OUT, .FEEDBACK_OUT);

/* File: tb/pops_ref_src.sv */
`timescale 1ns/1ps

module pops_ref_src
(
    input  wire logic pri_on,
    input  wire logic bak_on,
    output logic      clk_pri,
    output logic      clk_bak
);
    // a stopped source sits stuck low like a dead oscillator; periods are unrelated
    initial clk_pri = 1'b0;
    initial clk_bak = 1'b0;
    always #23 clk_pri = pri_on ? ~clk_pri : 1'b0;
    always #29 clk_bak = bak_on ? ~clk_bak : 1'b0;
endmodule : pops_ref_src

/* File: tb/pops_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end

module pops_tb_top
    import pops_pkg::*;
;
    typedef struct {logic [CNT_W-1:0] hi, lo, init; logic [TAP_W-1:0] tap;} pops_row_t;
    logic               CLK_SYS = 1'b0;
    logic               RST = 1'b1;
    logic [ADDR_W-1:0]  ADDR = '0;
    logic [DATA_W-1:0]  WR_DATA = '0, RD_DATA;
    logic               WR_STB = 1'b0, RD_STB = 1'b0;
    logic               SWITCH_REQUEST = 1'b0, RECONFIG_SHIFT_CLOCK = 1'b0;
    logic               REF_CLOCK_PRIMARY, REF_CLOCK_BACKUP, REF_MUX_OUT, FEEDBACK_OUT;
    logic               LOST_PRIMARY, LOST_BACKUP, ACTIVE_SOURCE;
    logic [NUM_OUT-1:0] DIV_OUT;
    logic               pri_on = 1'b1, bak_on = 1'b1;
    int                 fail_count = 0, checks = 0;
    pops_row_t rows [5] = '{'{9'h002, 9'h002, 9'h001, 3'h3}, '{9'h001, 9'h001, 9'h003, 3'h0},
        '{9'h003, 9'h005, 9'h002, 3'h7}, '{9'h004, 9'h001, 9'h001, 3'h5},
        '{9'h100, 9'h001, 9'h001, 3'h1}};

    always #5 CLK_SYS = ~CLK_SYS;

    pops_top u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
        .REF_CLOCK_PRIMARY(REF_CLOCK_PRIMARY), .REF_CLOCK_BACKUP(REF_CLOCK_BACKUP),
        .SWITCH_REQUEST(SWITCH_REQUEST), .RECONFIG_SHIFT_CLOCK(RECONFIG_SHIFT_CLOCK),
        .REF_MUX_OUT(REF_MUX_OUT), .LOST_PRIMARY(LOST_PRIMARY), .LOST_BACKUP(LOST_BACKUP),
        .ACTIVE_SOURCE(ACTIVE_SOURCE), .DIV_OUT(DIV_OUT), .FEEDBACK_OUT(FEEDBACK_OUT));
    pops_ref_src u_src (.pri_on(pri_on), .bak_on(bak_on),
        .clk_pri(REF_CLOCK_PRIMARY), .clk_bak(REF_CLOCK_BACKUP));

    function automatic pops_cnt_cfg_t cf(pops_row_t r);
        return '{pad: 2'h0, init: r.init, tap: r.tap, low: r.lo, high: r.hi};
    endfunction : cf

    task automatic cyc(int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : cyc

    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        WR_DATA <= d;
        WR_STB <= 1'b1;
        @(posedge CLK_SYS);
        WR_STB <= 1'b0;
    endtask : wr

    task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge CLK_SYS);
        RD_STB <= 1'b0;
        #1;
        d = RD_DATA;
    endtask : rd

    task automatic req(logic v, int n);
        @(posedge CLK_SYS);
        SWITCH_REQUEST <= v;
        cyc(n);
    endtask : req

    task automatic shift();
        @(posedge CLK_SYS);
        RECONFIG_SHIFT_CLOCK <= 1'b1;
        cyc(4);
        @(posedge CLK_SYS);
        RECONFIG_SHIFT_CLOCK <= 1'b0;
        cyc(4);
    endtask : shift

    // first rises of outputs 0..2, then high and low time of output 1, in system cycles
    task automatic meas(output int f [3], output int hi, output int lo);
        logic [2:0] p;
        int         d1;
        p = 3'h0;
        d1 = -1;
        hi = -1;
        lo = -1;
        f = '{-1, -1, -1};
        for (int n = 0; n < 7000 && lo < 0; n++)
        begin
            cyc(1);
            for (int k = 0; k < 3; k++)
                if (DIV_OUT[k] && !p[k] && f[k] < 0)
                    f[k] = n;
            if (!DIV_OUT[1] && p[1] && d1 < 0)
            begin
                d1 = n;
                hi = n - f[1];
            end
            if (DIV_OUT[1] && !p[1] && d1 >= 0)
                lo = n - d1;
            p = DIV_OUT[2:0];
        end
    endtask : meas

    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #500000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        logic [DATA_W-1:0] d;
        int                f [3];
        int                hi, lo, t;
        repeat (20) @(posedge CLK_SYS);
        RST <= 1'b0;
        cyc(30);
        `CHK("active", 1'b0, ACTIVE_SOURCE)
        `CHK("lost", 2'b00, {LOST_PRIMARY, LOST_BACKUP})
        rd(OFS_CTRL, d);
        `CHK("ctrl", 32'h0, d)
        for (int i = 0; i < NUM_CNT; i++)
        begin
            rd(OFS_CNT_BASE + 8'(4 * i), d);
            `CHK("cfg_rst", 32'(CNT_CFG_RST), d)
        end
        rd(8'hfc, d);
        `CHK("unmapped", 32'h0, d)
        wr(OFS_CNT_BASE + 8'h1c, 32'(cf('{9'h004, 9'h004, 9'h001, 3'h0})));
        foreach (rows[r])
        begin
            wr(OFS_CTRL, 32'h0);
            wr(OFS_CNT_BASE + 8'h04, 32'(cf(rows[r])));
            wr(OFS_CNT_BASE + 8'h08, 32'(cf('{rows[r].hi, rows[r].lo, 9'h001, rows[r].tap})));
            wr(OFS_CTRL, 32'h1);
            meas(f, hi, lo);
            `CHK("high", 8 * int'(rows[r].hi), hi)
            `CHK("low", 8 * int'(rows[r].lo), lo)
            `CHK("coarse", 8 * (int'(rows[r].init) - 1), f[1] - f[2])
            `CHK("fine", int'(rows[r].tap), (f[2] - f[0] + 64) % 8)
        end
        // counters still running: feedback and spare outputs over one full feedback period
        t = 0;
        hi = 0;
        lo = 0;
        repeat (64)
        begin
            cyc(1);
            t += int'(FEEDBACK_OUT);
            hi += int'(REF_MUX_OUT);
            lo += $countones(DIV_OUT[6:3]);
        end
        `CHK("fb_duty", 32, t)
        `CHK("div_duty", 128, lo)
        `CHK("mux_live", 1'b1, hi > 20 && hi < 44)
        wr(OFS_CTRL, 32'h0);
        rd(OFS_CNT_BASE + 8'h04, d);
        t = int'(d[20:18]);
        wr(OFS_STEP, 32'h1);
        rd(OFS_STEP, d);
        `CHK("pending", 1'b1, d[STEP_PEND_BIT])
        shift();
        repeat (8)
        begin
            wr(OFS_STEP, 32'h1);
            shift();
        end
        rd(OFS_STEP, d);
        `CHK("pending", 1'b0, d[STEP_PEND_BIT])
        rd(OFS_CNT_BASE + 8'h04, d);
        `CHK("tap_up", 3'(t + 9), d[20:18])
        wr(OFS_STEP, 32'h9);
        shift();
        rd(OFS_CNT_BASE + 8'h04, d);
        `CHK("tap_down", 3'(t + 8), d[20:18])
        req(1'b1, 60);
        `CHK("manual", 1'b1, ACTIVE_SOURCE)
        req(1'b0, 20);
        // high for three system cycles: fewer than three reference cycles
        req(1'b1, 2);
        req(1'b0, 60);
        `CHK("short_req", 1'b1, ACTIVE_SOURCE)
        req(1'b1, 60);
        `CHK("manual_back", 1'b0, ACTIVE_SOURCE)
        req(1'b0, 20);
        wr(OFS_CTRL, 32'h2);
        pri_on = 1'b0;
        cyc(80);
        `CHK("auto", 2'b11, {LOST_PRIMARY, ACTIVE_SOURCE})
        rd(OFS_STATUS, d);
        `CHK("status", 3'b101, d[2:0])
        bak_on = 1'b0;
        cyc(80);
        `CHK("both_lost", 2'b11, {LOST_BACKUP, ACTIVE_SOURCE})
        pri_on = 1'b1;
        cyc(80);
        `CHK("pri_back", 2'b00, {LOST_PRIMARY, ACTIVE_SOURCE})
        bak_on = 1'b1;
        cyc(80);
        `CHK("bak_back", 1'b0, LOST_BACKUP)
        wr(OFS_CTRL, 32'h4);
        req(1'b1, 60);
        `CHK("override", 1'b1, ACTIVE_SOURCE)
        bak_on = 1'b0;
        cyc(300);
        `CHK("blocked", 2'b11, {LOST_BACKUP, ACTIVE_SOURCE})
        req(1'b0, 80);
        `CHK("released", 1'b0, ACTIVE_SOURCE)
        bak_on = 1'b1;
        cyc(40);
        tally_and_finish();
    end
endmodule : pops_tb_top
